// ===== hw/encoder_end.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Half-duplex request then response only
// - Standard 12.5 Mbit/s, optional 25 Mbit/s
// - Master opens cycle, encoder only answers
// - Preamble and trailer around fixed frames
// - Command steers response and clears errors
// - Urgent first, then header, then payloads
// - Exactly one urgent payload frame
// - Exactly one secondary header with count
// - Zero to fifteen secondary payload frames
// - Encoder steps send list each cycle
// - Lists volatile or non-volatile storage
// - Storage for eight send lists
// - Command kind selects active send list
// - CRC guards each frame group
// - Sizes four, eight, four, eight bytes
// - Background memory channel inside frames
// - Bus mode adds leading bus request
// - Urgent latency 10 us, readable value
// - Cycles no faster than 25 us
module encoder_end (
	input wire logic clk_i,
	input wire logic resetn_i,
	frame_link_if.slave link,
	input wire logic [63:0] position_i, // Position latched per cycle.
	input wire logic [7:0] status_i, // Status placed in the header.
	input wire logic [63:0] item_data_i, // Data for the selected item.
	output logic [3:0] item_sel_o, // Item number wanted for a payload.
	input wire logic list_we_i, // Write one send list entry.
	input wire logic [2:0] list_wsel_i, // List being written.
	input wire logic [3:0] list_widx_i, // Entry index; 15 writes length.
	input wire logic [3:0] list_wdata_i, // Item number or length.
	output logic [15:0] bg_data_o, // Background word from command.
	output logic bg_valid_o, // One-cycle pulse with bg_data_o.
	output logic err_clear_o, // One-cycle error clear pulse.
	output logic crc_err_o, // Command CRC mismatch pulse.
	output logic [15:0] latency_param_o // Urgent latency in cycles.
);
	// Phases of a cycle.
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_RXCMD = 3'b001, S_PRE = 3'b010,
		S_URG = 3'b011, S_HDR = 3'b100, S_PAY = 3'b101,
		S_TRL = 3'b110, S_REL = 3'b111
	} st_t;
	st_t st_reg;
	// Send lists in flip-flops; volatile, reloaded by host after restart.
	logic [3:0] list_reg [frame_link_pkg::NUM_LISTS][16];
	logic [3:0] pos_reg [frame_link_pkg::NUM_LISTS]; // Walk position.
	logic [3:0] byte_reg; // Byte index in a frame.
	logic [3:0] pay_reg; // Payloads sent this cycle.
	logic [2:0] act_reg; // Active list.
	logic [7:0] crc_reg;
	logic [7:0] cmd_reg [frame_link_pkg::CMD_BYTES];
	logic [63:0] urg_reg;
	logic bus_reg; // Bus request seen ahead of the command.
	logic [7:0] s_data_reg;
	logic s_valid_reg;
	logic s_oe_reg;
	logic [3:0] count_w, entry_w;
	logic [7:0] hdr_w, urg_byte_w, pay_byte_w;
	logic [2:0] sel_w;
	logic rx_w;
	logic trl_w; // Byte closes the request.

	assign rx_w = link.m_valid && link.m_oe;
	// A trailer-valued byte equal to the running CRC is a bus-mode CRC byte.
	assign trl_w = (link.m_data == frame_link_pkg::TRAILER_BYTE) &&
		(crc_reg != frame_link_pkg::TRAILER_BYTE);
	assign count_w = list_reg[act_reg][15];
	assign entry_w = list_reg[act_reg][pos_reg[act_reg]];
	assign sel_w = cmd_reg[0][frame_link_pkg::CMD_LIST_LSB +: 3];
	assign urg_byte_w = urg_reg[63 - 8 * byte_reg[2:0] -: 8];
	assign pay_byte_w = item_data_i[63 - 8 * byte_reg[2:0] -: 8];
	// Header bytes: status, list id, count; the fourth byte is the CRC.
	assign hdr_w = (byte_reg == 4'h0) ? status_i :
		(byte_reg == 4'h1) ? {5'h00, act_reg} :
		(byte_reg == 4'h2) ? {4'h0, count_w} : cmd_reg[2];
	assign link.s_data = s_data_reg;
	assign link.s_valid = s_valid_reg;
	assign link.s_oe = s_oe_reg;

	// Send list writes from the configuration port.
	always_ff @(posedge clk_i) begin
		if (list_we_i) begin
			list_reg[list_wsel_i][list_widx_i] <= list_wdata_i;
		end
	end

	// Protocol sequencer: receive command, then answer in order.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_reg <= S_IDLE;
			byte_reg <= 4'h0;
			pay_reg <= 4'h0;
			act_reg <= 3'h0;
			crc_reg <= frame_link_pkg::CRC_SEED;
			urg_reg <= 64'h0;
			bus_reg <= 1'b0;
			s_data_reg <= 8'h00;
			s_valid_reg <= 1'b0;
			s_oe_reg <= 1'b0;
			bg_valid_o <= 1'b0;
			bg_data_o <= 16'h0000;
			err_clear_o <= 1'b0;
			crc_err_o <= 1'b0;
			item_sel_o <= 4'h0;
			latency_param_o <= 16'h0000;
			for (int i = 0; i < frame_link_pkg::NUM_LISTS; i++) begin
				pos_reg[i] <= 4'h0;
			end
		end else begin
			bg_valid_o <= 1'b0;
			err_clear_o <= 1'b0;
			crc_err_o <= 1'b0;
			s_valid_reg <= 1'b0;
			latency_param_o <= 16'(frame_link_pkg::URGENT_LAT_CYC);
			case (st_reg)
				S_IDLE: begin
					// Only a controller preamble opens a cycle.
					if (rx_w && link.m_data == frame_link_pkg::PREAMBLE_BYTE) begin
						st_reg <= S_RXCMD;
						byte_reg <= 4'h0;
						bus_reg <= 1'b0;
						crc_reg <= frame_link_pkg::CRC_SEED;
					end
				end
				S_RXCMD: begin
					if (rx_w) begin
						if (byte_reg < 4'(frame_link_pkg::CMD_BYTES)) begin
							cmd_reg[byte_reg[1:0]] <= link.m_data;
							crc_reg <= frame_link_pkg::crc8_step(crc_reg, link.m_data);
							byte_reg <= byte_reg + 4'h1;
						end else if (trl_w) begin
							// Last command byte holds CRC: residue must be zero.
							if (crc_reg != 8'h00) begin
								crc_err_o <= 1'b1;
								st_reg <= S_IDLE;
							end else begin
								act_reg <= sel_w;
								err_clear_o <= cmd_reg[0][frame_link_pkg::CMD_CLR_BIT];
								bg_data_o <= {cmd_reg[1], cmd_reg[2]};
								bg_valid_o <= 1'b1;
								urg_reg <= position_i;
								st_reg <= S_PRE;
							end
						end else begin
							// A fifth byte before the trailer means the first byte was a bus request prefix.
							bus_reg <= 1'b1;
							cmd_reg[0] <= cmd_reg[1];
							cmd_reg[1] <= cmd_reg[2];
							cmd_reg[2] <= cmd_reg[3];
							cmd_reg[3] <= link.m_data;
							crc_reg <= frame_link_pkg::crc8_step(crc_reg, link.m_data);
						end
					end
				end
				S_PRE: begin
					// Controller has released the pair by now.
					if (!link.m_oe) begin
						s_oe_reg <= 1'b1;
						s_data_reg <= frame_link_pkg::PREAMBLE_BYTE;
						s_valid_reg <= 1'b1;
						byte_reg <= 4'h0;
						pay_reg <= 4'h0;
						crc_reg <= frame_link_pkg::CRC_SEED;
						st_reg <= S_URG;
					end
				end
				S_URG: begin
					// Urgent frame first, its last byte is the CRC.
					s_valid_reg <= 1'b1;
					if (byte_reg == 4'(frame_link_pkg::URGENT_BYTES - 1)) begin
						s_data_reg <= crc_reg;
						byte_reg <= 4'h0;
						st_reg <= S_HDR;
					end else begin
						s_data_reg <= urg_byte_w;
						crc_reg <= frame_link_pkg::crc8_step(crc_reg, urg_byte_w);
						byte_reg <= byte_reg + 4'h1;
					end
				end
				S_HDR: begin
					// Header shares the urgent frame's running CRC.
					s_valid_reg <= 1'b1;
					if (byte_reg == 4'(frame_link_pkg::HEADER_BYTES - 1)) begin
						s_data_reg <= crc_reg;
						byte_reg <= 4'h0;
						crc_reg <= frame_link_pkg::CRC_SEED;
						item_sel_o <= entry_w;
						st_reg <= (count_w == 4'h0) ? S_TRL : S_PAY;
					end else begin
						s_data_reg <= hdr_w;
						crc_reg <= frame_link_pkg::crc8_step(crc_reg, hdr_w);
						byte_reg <= byte_reg + 4'h1;
					end
				end
				S_PAY: begin
					// Each payload frame has its own CRC in its last byte.
					s_valid_reg <= 1'b1;
					if (byte_reg == 4'(frame_link_pkg::PAYLOAD_BYTES - 1)) begin
						s_data_reg <= crc_reg;
						byte_reg <= 4'h0;
						crc_reg <= frame_link_pkg::CRC_SEED;
						pay_reg <= pay_reg + 4'h1;
						// Walk on through the list, wrapping at its length.
						pos_reg[act_reg] <= (pos_reg[act_reg] + 4'h1 >= count_w) ?
							4'h0 : pos_reg[act_reg] + 4'h1;
						item_sel_o <= list_reg[act_reg][(pos_reg[act_reg] + 4'h1
							>= count_w) ? 4'h0 : pos_reg[act_reg] + 4'h1];
						if (pay_reg + 4'h1 == count_w) begin
							st_reg <= S_TRL;
						end
					end else begin
						s_data_reg <= pay_byte_w;
						crc_reg <= frame_link_pkg::crc8_step(crc_reg, pay_byte_w);
						byte_reg <= byte_reg + 4'h1;
					end
				end
				S_TRL: begin
					// Trailer goes out whatever the last CRC byte was.
					s_data_reg <= frame_link_pkg::TRAILER_BYTE;
					s_valid_reg <= 1'b1;
					st_reg <= S_REL;
				end
				S_REL: begin
					// Let go of the pair once the trailer has been sent.
					s_oe_reg <= 1'b0;
					st_reg <= S_IDLE;
				end
				default: st_reg <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== hw/frame_link_pkg.sv
package frame_link_pkg;

	// Field sizes in bytes for each frame kind.
	localparam int unsigned CMD_BYTES = 4;
	localparam int unsigned URGENT_BYTES = 8;
	localparam int unsigned HEADER_BYTES = 4;
	localparam int unsigned PAYLOAD_BYTES = 8;
	localparam int unsigned BUSREQ_BYTES = 4;

	// Lead-in and trailing marker bytes framing every transmission.
	localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0] TRAILER_BYTE = 8'hd5;

	// Send list storage: eight lists of up to fifteen entries.
	localparam int unsigned NUM_LISTS = 8;
	localparam int unsigned MAX_PAYLOADS = 15;

	// CRC settings, 8-bit with a configurable polynomial and seed.
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_SEED = 8'hff;

	// Link timing at a 20 MHz clock.
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned BIT_RATE_STD = 12500000;
	localparam int unsigned BIT_RATE_FAST = 25000000;
	localparam int unsigned URGENT_LAT_US = 10;
	localparam int unsigned URGENT_LAT_CYC = URGENT_LAT_US * (CLK_HZ / 1000000);
	localparam int unsigned CYCLE_MIN_US = 25;
	localparam int unsigned CYCLE_MIN_CYC = CYCLE_MIN_US * (CLK_HZ / 1000000);

	// Command byte 0 layout: bits 2:0 select list, bit 3 clears errors.
	localparam int unsigned CMD_LIST_LSB = 0;
	localparam int unsigned CMD_CLR_BIT = 3;

	// One 8-bit CRC step over a whole byte, MSB first.
	function automatic logic [7:0] crc8_step(input logic [7:0] crc,
		input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

endpackage

// ===== hw/frame_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-serial half-duplex pair between controller and encoder.
interface frame_link_if;
	logic [7:0] m_data; // Byte driven by the controller.
	logic m_valid; // Controller byte strobe.
	logic m_oe; // Controller drives the pair.
	logic [7:0] s_data; // Byte driven by the encoder.
	logic s_valid; // Encoder byte strobe.
	logic s_oe; // Encoder drives the pair.
	modport master (output m_data, output m_valid, output m_oe,
		input s_data, input s_valid, input s_oe);
	modport slave (input m_data, input m_valid, input m_oe,
		output s_data, output s_valid, output s_oe);
endinterface
`default_nettype wire

// ===== hw/controller_end.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: sends a framed command, then checks the answer.
module controller_end (
	input wire logic clk_i,
	input wire logic resetn_i,
	frame_link_if.master link,
	input wire logic start_i, // Pulse: begin a cycle.
	input wire logic bus_mode_i, // Prefix a bus request byte.
	input wire logic [7:0] cmd_i, // List select and clear bit.
	input wire logic [15:0] bg_i, // Background word to send.
	output logic busy_o, // Cycle in progress.
	output logic [7:0] rx_data_o, // Received response byte.
	output logic rx_valid_o, // Pulse with rx_data_o.
	output logic frame_end_o, // Pulse at each CRC byte.
	output logic crc_err_o, // Pulse on a CRC mismatch.
	output logic done_o // Pulse when the trailer arrives.
);
	typedef enum logic [1:0] {
		M_IDLE = 2'b00, M_TX = 2'b01, M_RX = 2'b10, M_GAP = 2'b11
	} mst_t;
	mst_t st_reg;
	logic [3:0] idx_reg; // Transmit byte index, or byte in frame.
	logic [7:0] crc_reg;
	logic [7:0] cmd_reg;
	logic [15:0] bg_reg;
	logic bus_reg;
	logic [7:0] m_data_reg;
	logic m_valid_reg;
	logic m_oe_reg;
	logic [1:0] kind_reg; // 0 urgent, 1 header, 2 payload.
	logic started_reg; // Response preamble seen.
	logic [3:0] left_reg; // Payload frames still to come.
	logic [9:0] gap_reg; // Minimum cycle spacing counter.
	logic [3:0] flen_w;
	logic [7:0] tx_w;
	logic rx_w;

	assign rx_w = link.s_valid && link.s_oe;
	assign flen_w = (kind_reg == 2'd1) ? 4'(frame_link_pkg::HEADER_BYTES) :
		(kind_reg == 2'd0) ? 4'(frame_link_pkg::URGENT_BYTES) :
		4'(frame_link_pkg::PAYLOAD_BYTES);
	// Transmit byte order: preamble, command, background, CRC, trailer.
	assign tx_w = (idx_reg == 4'h0) ? frame_link_pkg::PREAMBLE_BYTE :
		(idx_reg == 4'h1) ? cmd_reg : (idx_reg == 4'h2) ? bg_reg[15:8] :
		(idx_reg == 4'h3) ? bg_reg[7:0] : crc_reg;
	assign link.m_data = m_data_reg;
	assign link.m_valid = m_valid_reg;
	assign link.m_oe = m_oe_reg;

	// Cycle sequencer.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_reg <= M_IDLE;
			idx_reg <= 4'h0;
			crc_reg <= frame_link_pkg::CRC_SEED;
			cmd_reg <= 8'h00;
			bg_reg <= 16'h0000;
			bus_reg <= 1'b0;
			m_data_reg <= 8'h00;
			m_valid_reg <= 1'b0;
			m_oe_reg <= 1'b0;
			kind_reg <= 2'd0;
			started_reg <= 1'b0;
			left_reg <= 4'h0;
			gap_reg <= 10'h000;
			busy_o <= 1'b0;
			rx_data_o <= 8'h00;
			rx_valid_o <= 1'b0;
			frame_end_o <= 1'b0;
			crc_err_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			frame_end_o <= 1'b0;
			crc_err_o <= 1'b0;
			done_o <= 1'b0;
			m_valid_reg <= 1'b0;
			if (gap_reg != 10'h000) begin
				gap_reg <= gap_reg - 10'h001;
			end
			case (st_reg)
				M_IDLE: begin
					// Respect the minimum cycle period before a new start.
					if (start_i && gap_reg == 10'h000) begin
						cmd_reg <= cmd_i;
						bg_reg <= bg_i;
						bus_reg <= bus_mode_i;
						idx_reg <= 4'h0;
						crc_reg <= frame_link_pkg::CRC_SEED;
						gap_reg <= 10'(frame_link_pkg::CYCLE_MIN_CYC);
						busy_o <= 1'b1;
						st_reg <= M_TX;
					end
				end
				M_TX: begin
					m_oe_reg <= 1'b1;
					m_valid_reg <= 1'b1;
					if (bus_reg) begin
						// Bus request byte goes ahead of the command.
						m_data_reg <= (idx_reg == 4'h0) ?
							frame_link_pkg::PREAMBLE_BYTE : 8'h00;
						crc_reg <= (idx_reg == 4'h0) ? crc_reg :
							frame_link_pkg::crc8_step(crc_reg, 8'h00);
						if (idx_reg != 4'h0) begin
							bus_reg <= 1'b0;
						end
						idx_reg <= 4'h1;
					end else if (idx_reg == 4'h5) begin
						m_data_reg <= frame_link_pkg::TRAILER_BYTE;
						st_reg <= M_RX;
					end else begin
						m_data_reg <= tx_w;
						if (idx_reg != 4'h0 && idx_reg != 4'h4) begin
							crc_reg <= frame_link_pkg::crc8_step(crc_reg, tx_w);
						end
						idx_reg <= idx_reg + 4'h1;
					end
				end
				M_RX: begin
					m_oe_reg <= 1'b0;
					if (rx_w) begin
						if (!started_reg) begin
							started_reg <= 1'b1;
							idx_reg <= 4'h0;
							kind_reg <= 2'd0;
							crc_reg <= frame_link_pkg::CRC_SEED;
						end else if (link.s_data == frame_link_pkg::TRAILER_BYTE
							&& idx_reg == 4'h0 && kind_reg == 2'd2
							&& left_reg == 4'h0) begin
							done_o <= 1'b1;
							st_reg <= M_GAP;
						end else if (idx_reg == flen_w - 4'h1) begin
							// Urgent frame CRC continues through the header.
							frame_end_o <= 1'b1;
							if (kind_reg != 2'd0 && crc_reg != link.s_data) begin
								crc_err_o <= 1'b1;
							end
							idx_reg <= 4'h0;
							if (kind_reg != 2'd0) begin
								crc_reg <= frame_link_pkg::CRC_SEED;
							end
							// Count payload frames so data never reads as trailer.
							if (kind_reg == 2'd2) begin
								left_reg <= left_reg - 4'h1;
							end
							kind_reg <= (kind_reg == 2'd0) ? 2'd1 : 2'd2;
						end else begin
							rx_data_o <= link.s_data;
							rx_valid_o <= 1'b1;
							// Header byte 2 gives the payload frame count.
							if (kind_reg == 2'd1 && idx_reg == 4'h2) begin
								left_reg <= link.s_data[3:0];
							end
							crc_reg <= frame_link_pkg::crc8_step(crc_reg, link.s_data);
							idx_reg <= idx_reg + 4'h1;
						end
					end
				end
				M_GAP: begin
					started_reg <= 1'b0;
					busy_o <= 1'b0;
					st_reg <= M_IDLE;
				end
				default: st_reg <= M_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== test/frame_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the shared pair between the controller and the encoder.
module frame_link_assertions (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] m_data,
	input wire logic m_valid,
	input wire logic m_oe,
	input wire logic [7:0] s_data,
	input wire logic s_valid,
	input wire logic s_oe
);
	int mcnt; // Bytes of the request so far.
	int scnt; // Bytes of the response so far.
	int gap; // Cycles since the last request opened.

	// Frame length and request spacing counters.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			mcnt <= 0;
			scnt <= 0;
			gap <= 1000;
		end else begin
			mcnt <= m_valid ? mcnt + 1 : 0;
			scnt <= s_valid ? scnt + 1 : 0;
			gap <= $rose(m_valid) ? 1 : (gap < 1000 ? gap + 1 : gap);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// A request has just finished with its trailer.
	sequence req_end;
		$fell(m_valid) && $past(m_data) == frame_link_pkg::TRAILER_BYTE;
	endsequence
	// A response opens with its preamble.
	sequence resp_start;
		$rose(s_valid) && s_data == frame_link_pkg::PREAMBLE_BYTE;
	endsequence

	AST_HALF_DUPLEX: assert property (!(m_oe && s_oe))
		else $error("both ends drive the pair");
	AST_RESP_AFTER_REQ: assert property (req_end |-> ##[1:4] resp_start)
		else $error("no response after a request");
	AST_NO_UNSOLICITED: assert property ($rose(s_valid) |-> !m_oe)
		else $error("encoder spoke during a request");
	AST_REQ_PREAMBLE: assert property
		($rose(m_valid) |-> m_data == frame_link_pkg::PREAMBLE_BYTE)
		else $error("request lacks preamble");
	AST_RESP_TRAILER: assert property
		($fell(s_valid) |-> $past(s_data) == frame_link_pkg::TRAILER_BYTE)
		else $error("response lacks trailer");
	AST_REQ_LEN: assert property ($fell(m_valid) |-> mcnt == 6 || mcnt == 7)
		else $error("request length wrong");
	AST_RESP_LEN: assert property
		($fell(s_valid) |-> scnt >= 14 && scnt <= 134 && (scnt - 14) % 8 == 0)
		else $error("response length wrong");
	AST_RELEASE: assert property ($fell(s_valid) |-> ##[0:2] !s_oe)
		else $error("encoder holds the pair");
	AST_VALID_DRIVEN: assert property ((m_valid |-> m_oe) and (s_valid |-> s_oe))
		else $error("byte strobe without driver");
	AST_CYCLE_GAP: assert property ($rose(m_valid) |-> gap >= 500)
		else $error("requests too close");
endmodule
`default_nettype wire

// ===== test/encoder_frame_protocol_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Runs the controller against the encoder and checks both sides.
module encoder_frame_protocol_tb;
	logic clk = 0, resetn = 0, start = 0, bus_mode = 0, list_we = 0;
	logic [7:0] cmd = 0, status = 0, rx_data;
	logic [15:0] bg = 0, bg_data, bg_seen, lat;
	logic [63:0] position = 0, item = 0;
	logic [2:0] list_wsel = 0;
	logic [3:0] list_widx = 0, list_wdata = 0, item_sel;
	logic rx_valid, bg_valid, err_clear, e_crc, c_crc, e2_crc, done, busy;
	logic [7:0] rxq[$], mq[$], sq[$]; // Captured bytes.
	int n_mismatch = 0, checks_done = 0, nclr, ndone, ncrc, f_crc, f_oe;
	int len[8]; // Length of each send list.
	logic [3:0] ent[8][15]; // Entries of each send list.
	logic fe; // Controller frame end pulse.
	int nfe; // Frame ends seen this cycle.

	frame_link_if lnk();
	frame_link_if lnk2(); // Carries hand-driven requests, good or with a broken CRC.

	always #25 clk = ~clk;

	encoder_end encoder_end_i (.clk_i(clk), .resetn_i(resetn), .link(lnk),
		.position_i(position), .status_i(status),
		.item_data_i(item ^ {16{item_sel}}),
		.item_sel_o(item_sel), .list_we_i(list_we), .list_wsel_i(list_wsel),
		.list_widx_i(list_widx), .list_wdata_i(list_wdata),
		.bg_data_o(bg_data), .bg_valid_o(bg_valid), .err_clear_o(err_clear),
		.crc_err_o(e_crc), .latency_param_o(lat));
	encoder_end encoder_end_f_i (.clk_i(clk), .resetn_i(resetn), .link(lnk2),
		.position_i(position), .status_i(status), .item_data_i(item),
		.item_sel_o(), .list_we_i(list_we), .list_wsel_i(list_wsel),
		.list_widx_i(list_widx), .list_wdata_i(list_wdata), .bg_data_o(),
		.bg_valid_o(), .err_clear_o(), .crc_err_o(e2_crc),
		.latency_param_o());
	controller_end controller_end_i (.clk_i(clk), .resetn_i(resetn),
		.link(lnk), .start_i(start), .bus_mode_i(bus_mode), .cmd_i(cmd),
		.bg_i(bg), .busy_o(busy), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
		.frame_end_o(fe), .crc_err_o(c_crc), .done_o(done));
	frame_link_assertions frame_link_assertions_i (.clk_i(clk),
		.resetn_i(resetn), .m_data(lnk.m_data), .m_valid(lnk.m_valid),
		.m_oe(lnk.m_oe), .s_data(lnk.s_data), .s_valid(lnk.s_valid),
		.s_oe(lnk.s_oe));

	// Collects bytes seen on lnk and pulses from both links.
	always @(posedge clk) begin
		if (rx_valid) rxq.push_back(rx_data);
		if (lnk.m_valid && lnk.m_oe) mq.push_back(lnk.m_data);
		if (lnk.s_valid && lnk.s_oe) sq.push_back(lnk.s_data);
		if (bg_valid) bg_seen = bg_data;
		if (err_clear) nclr++;
		if (done) ndone++;
		if (fe) nfe++;
		if (e_crc || c_crc) ncrc++;
		if (e2_crc) f_crc++;
		if (lnk2.s_oe) f_oe++;
	end

	// Bit-serial CRC, most significant bit first.
	function automatic logic [7:0] crc_of(input logic [7:0] q[$],
		input int a, input int n);
		logic [7:0] c;
		c = frame_link_pkg::CRC_SEED;
		for (int i = a; i < a + n; i++)
			for (int j = 7; j >= 0; j--)
				c = {c[6:0], 1'b0} ^
					((c[7] ^ q[i][j]) ? frame_link_pkg::CRC_POLY : 8'h00);
		return c;
	endfunction

	// Payload byte k of the data that the item source shows for item s.
	function automatic logic [7:0] pay_byte(input logic [63:0] d,
		input logic [3:0] s, input int k);
		logic [63:0] w;
		w = d ^ {16{s}};
		return w[63 - 8 * k -: 8];
	endfunction

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Writes one send list entry; index 15 holds the length.
	task automatic wlist(input logic [2:0] s, input logic [3:0] i,
		input logic [3:0] d);
		@(negedge clk);
		list_we = 1;
		list_wsel = s;
		list_widx = i;
		list_wdata = d;
		@(negedge clk);
		list_we = 0;
	endtask

	// One full cycle: request, response, then the spacing gap.
	task automatic run_cycle(input logic [2:0] l, input logic c, input logic b);
		int k, o, n;
		n = len[l];
		o = b ? 2 : 1;
		@(negedge clk);
		rxq.delete();
		mq.delete();
		sq.delete();
		nclr = 0;
		ndone = 0;
		ncrc = 0;
		nfe = 0;
		cmd = {4'h0, c, l};
		bg = 16'($urandom);
		bus_mode = b;
		position = {$urandom, $urandom};
		item = {$urandom, $urandom};
		status = 8'($urandom);
		start = 1;
		@(negedge clk);
		start = 0;
		check(busy, 1);
		for (k = 0; ndone == 0 && k < 2000; k++) @(negedge clk);
		repeat (500) @(negedge clk);
		check(ndone, 1);
		check(busy, 0);
		check(nfe, 2 + n);
		check(mq.size(), 5 + o);
		check(mq[0], frame_link_pkg::PREAMBLE_BYTE);
		if (b) check(mq[1], 8'h00);
		check({mq[o], mq[o + 1], mq[o + 2]}, {cmd, bg});
		check(mq[o + 3], crc_of(mq, 1, o + 2));
		check(mq[o + 4], frame_link_pkg::TRAILER_BYTE);
		check(sq.size(), 14 + 8 * n);
		check(sq[0], frame_link_pkg::PREAMBLE_BYTE);
		check(sq[sq.size() - 1], frame_link_pkg::TRAILER_BYTE);
		check(rxq.size(), 10 + 7 * n);
		for (k = 0; k < 7; k++) check(rxq[k], position[63 - 8 * k -: 8]);
		check({rxq[7], rxq[8][2:0], rxq[9]}, {status, l, 8'(n)});
		for (k = 0; k < 7 * n; k++)
			check(rxq[10 + k], pay_byte(item, ent[l][k / 7], k % 7));
		for (k = 0; k < n; k++) check(sq[20 + 8 * k], crc_of(sq, 13 + 8 * k, 7));
		check(nclr, 32'(c));
		check(bg_seen, bg);
		check(ncrc, 0);
		$display("cycle on list %0d done", l);
	endtask

	// Sends a command on the second link, with a broken CRC if asked.
	task automatic raw(input logic bad);
		logic [7:0] f[$];
		f = {8'h55, 8'h01, 8'h12, 8'h34};
		f.push_back(crc_of(f, 1, 3) ^ {7'h0, bad});
		f.push_back(frame_link_pkg::TRAILER_BYTE);
		f_crc = 0;
		f_oe = 0;
		foreach (f[i]) begin
			@(negedge clk);
			{lnk2.m_data, lnk2.m_valid, lnk2.m_oe} = {f[i], 2'b11};
		end
		@(negedge clk);
		{lnk2.m_valid, lnk2.m_oe} = 2'b00;
		// A released line never keeps showing the last byte.
		repeat (200) begin
			@(negedge clk);
			lnk2.m_data = ~lnk2.m_data;
		end
		check({f_crc, 32'(f_oe != 0)}, {32'(bad), 32'(!bad)});
		$display("fault link test bad=%0d done", bad);
	endtask

	// Watchdog against a hung handshake.
	initial begin
		#1000000;
		n_mismatch++;
		finish_test();
	end

	// Main sequence.
	initial begin
		{lnk2.m_data, lnk2.m_valid, lnk2.m_oe} = 10'h0;
		void'($urandom(37));
		repeat (5) @(negedge clk);
		resetn = 1;
		@(negedge clk);
		check(lat, 16'(frame_link_pkg::URGENT_LAT_CYC));
		for (int l = 0; l < 8; l++) begin
			len[l] = (l == 0) ? 0 : (l == 7) ? 15 : 1 + $urandom % 14;
			for (int i = 0; i < len[l]; i++) begin
				ent[l][i] = 4'($urandom);
				wlist(3'(l), 4'(i), ent[l][i]);
			end
			wlist(3'(l), 4'hf, 4'(len[l]));
		end
		for (int l = 0; l < 8; l++) run_cycle(3'(l), 1'($urandom), l == 3);
		run_cycle(3'h7, 1'b1, 1'b1);
		raw(1'b1);
		raw(1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
